/* hw/cgpio_regs.svh */
// Register offsets, field positions, reset values and timing counts of the pin port
`ifndef CGPIO_REGS_SVH
`define CGPIO_REGS_SVH
`define CGPIO_OFF_CMD 8'h00
`define CGPIO_OFF_ARG 8'h04
`define CGPIO_OFF_RESP 8'h08
`define CGPIO_OFF_STAT 8'h0C
`define CGPIO_OFF_BOOT 8'h10
`define CGPIO_CMD_SET 8'h22
`define CGPIO_CMD_READ 8'h23
`define CGPIO_ACK_BIT 8'h40
`define CGPIO_NUM_PINS 8'h05
`define CGPIO_VAL_HIGH 8'h64
`define CGPIO_FUNC_BIT 3
`define CGPIO_S_BIT 0
`define CGPIO_F_BIT 1
`define CGPIO_R_BIT 2
`define CGPIO_SAMPLE_HZ 32
`define CGPIO_PWM_HZ 100
`define CGPIO_CLK_HZ 200000000
`define CGPIO_SAMPLE_CYC (`CGPIO_CLK_HZ / `CGPIO_SAMPLE_HZ)
`define CGPIO_PWM_STEP_CYC (`CGPIO_CLK_HZ / (`CGPIO_PWM_HZ * 100))
`define CGPIO_CFG_RST0 4'h2
`define CGPIO_CFG_RST1 4'h3
`define CGPIO_CFG_RST2 4'h2
`define CGPIO_CFG_RST3 4'h2
`define CGPIO_CFG_RST4 4'h3
`endif

/* hw/cgpio_pkg.sv */
// Types of the command driven pin port
package cgpio_pkg;
  typedef enum logic [2:0] {
    CGPIO_DM_UP_RDN = 3'b000,
    CGPIO_DM_STRONG = 3'b001,
    CGPIO_DM_HIZ = 3'b010,
    CGPIO_DM_RUP_DN = 3'b011,
    CGPIO_DM_SUP_Z = 3'b100,
    CGPIO_DM_SLOW = 3'b101,
    CGPIO_DM_RSVD = 3'b110,
    CGPIO_DM_Z_SDN = 3'b111
  } cgpio_drive_type;
endpackage : cgpio_pkg

/* hw/cgpio_pin_drv.sv */
// Per-pin PWM generator and drive-mode decoder
`timescale 1ns/100ps
`default_nettype none
`include "cgpio_regs.svh"
module cgpio_pin_drv (
  // Clock
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic step_i,
  // Setting
  input wire logic [7:0] value_i,
  input wire logic [2:0] mode_i,
  input wire logic user_i,
  input wire logic dflt_o_i,
  input wire logic dflt_oe_i,
  // Pin
  output logic pin_o,
  output logic pin_oe_o,
  output logic pull_up_o,
  output logic pull_dn_o,
  output logic slow_o
);
  logic [6:0] phase_r;
  logic [6:0] phase_nxt;
  logic lvl_r, lvl_nxt;
  logic oe_r, oe_nxt, o_r, o_nxt, pu_r, pu_nxt, pd_r, pd_nxt, sl_r, sl_nxt;

  always_comb begin
    phase_nxt = phase_r;
    if (step_i) begin
      phase_nxt = (phase_r == 7'h63) ? 7'h00 : phase_r + 7'h01;
    end
    // RL6 duty decode
    if (value_i == 8'h00) begin
      lvl_nxt = 1'b0;
    end else if (value_i >= `CGPIO_VAL_HIGH) begin
      lvl_nxt = 1'b1;
    end else begin
      lvl_nxt = ({1'b0, phase_r} < value_i);
    end
    o_nxt = lvl_r;
    oe_nxt = 1'b0;
    pu_nxt = 1'b0;
    pd_nxt = 1'b0;
    sl_nxt = 1'b0;
    // RL7 drive modes
    unique case (cgpio_pkg::cgpio_drive_type'(mode_i))
      cgpio_pkg::CGPIO_DM_UP_RDN: begin
        oe_nxt = lvl_r;
        pd_nxt = ~lvl_r;
      end
      cgpio_pkg::CGPIO_DM_STRONG: oe_nxt = 1'b1;
      cgpio_pkg::CGPIO_DM_HIZ: oe_nxt = 1'b0;
      cgpio_pkg::CGPIO_DM_RUP_DN: begin
        oe_nxt = ~lvl_r;
        pu_nxt = lvl_r;
      end
      cgpio_pkg::CGPIO_DM_SUP_Z: begin
        oe_nxt = lvl_r;
        sl_nxt = 1'b1;
      end
      cgpio_pkg::CGPIO_DM_SLOW: begin
        oe_nxt = 1'b1;
        sl_nxt = 1'b1;
      end
      cgpio_pkg::CGPIO_DM_Z_SDN: begin
        oe_nxt = ~lvl_r;
        sl_nxt = 1'b1;
      end
      default: oe_nxt = 1'b0;
    endcase
    // RL9 default function takes the pin
    if (!user_i) begin
      o_nxt = dflt_o_i;
      oe_nxt = dflt_oe_i;
      pu_nxt = 1'b0;
      pd_nxt = 1'b0;
      sl_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= 7'h00;
      lvl_r <= 1'b0;
      o_r <= 1'b0;
      oe_r <= 1'b0;
      pu_r <= 1'b0;
      pd_r <= 1'b0;
      sl_r <= 1'b0;
    end else if (ce_i) begin
      phase_r <= phase_nxt;
      lvl_r <= lvl_nxt;
      o_r <= o_nxt;
      oe_r <= oe_nxt;
      pu_r <= pu_nxt;
      pd_r <= pd_nxt;
      sl_r <= sl_nxt;
    end
  end

  assign pin_o = o_r;
  assign pin_oe_o = oe_r;
  assign pull_up_o = pu_r;
  assign pull_dn_o = pd_r;
  assign slow_o = sl_r;

  // RL6 constant high holds
  a_const_high: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
    (ce_i && value_i == `CGPIO_VAL_HIGH) |=> lvl_r)
    else $error("value 100 did not give constant high");
endmodule : cgpio_pin_drv
`default_nettype wire

/* hw/cgpio_port.sv */
// Command driven five-pin port with 32 Hz sampling, edge flags and PWM
// Operation
// RL1: Five pins indexed 0 to 4; indices 5 to 255 select nothing.
// RL2: Every pin sampled continuously at 32 Hz regardless of host requests.
// RL3: Per pin, rising and falling edges remembered since that pin's last query.
// RL4: Level and edges derived only from periodic samples, so bounce is hidden.
// RL5: Set command 34 takes two bytes, or three to also configure.
// RL6: Value 0 low, 1-99 PWM duty at 100 Hz, 100 high, rest invalid.
// RL7: Three-bit drive mode selects drive for output high and low.
// RL8: Host never writes reserved drive mode 110.
// RL9: Function bit 0 gives default pin use, 1 gives user control.
// RL10: Host writes zeros into configuration bits above the function bit.
// RL11: Accepted set answered with type 34 ORed 0x40, no data.
// RL12: Read answer: index, then level, falling flag, rising flag in low bits.
// RL13: Edge flags set on any edge since last poll, restart after report.
// RL14: Reported level is the sampled pin, not the requested output.
// RL15: Sampling free-runs; pulses between two samples go unseen.
// RL16: Third answer byte is the requested value 0 to 100 as written.
// RL17: Fourth answer byte is function and drive mode, reserved bits zero.
// RL18: Pins 1-3 default to host power functions, pin 4 one-wire bus.
// RL19: Pin configuration is saved to boot state and restored at reset; here reset reloads the fixed defaults into both instead.
// RL20: Read command carries pin index; answer type is command ORed 0x40.
`timescale 1ns/100ps
`default_nettype none
`include "cgpio_regs.svh"
module cgpio_port #(
  parameter int SAMPLE_CYC = `CGPIO_SAMPLE_CYC,
  parameter int PWM_STEP_CYC = `CGPIO_PWM_STEP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pins
  input wire logic [4:0] pin_i,
  output logic [4:0] pin_o,
  output logic [4:0] pin_oe_o,
  output logic [4:0] pull_up_o,
  output logic [4:0] pull_dn_o,
  output logic [4:0] slow_o,
  // Default functions
  input wire logic [4:0] dflt_o_i,
  input wire logic [4:0] dflt_oe_i
);
  logic [4:0] sync1_r, sync2_r;
  logic [31:0] samp_cnt_r, samp_cnt_nxt;
  logic [31:0] step_cnt_r, step_cnt_nxt;
  logic step_r, step_nxt, tick;
  logic [4:0] lvl_r, lvl_nxt, rise_r, rise_nxt, fall_r, fall_nxt;
  logic [7:0] val_r [5];
  logic [7:0] val_nxt [5];
  logic [3:0] cfg_r [5];
  logic [3:0] cfg_nxt [5];
  logic [3:0] boot_r [5];
  logic [3:0] boot_nxt [5];
  logic [31:0] arg_r, arg_nxt, resp_r, resp_nxt, dat_nxt;
  logic [7:0] rtype_r, rtype_nxt;
  logic ack_nxt;
  logic wr, rd;
  logic cmd_go, poll0;

  function automatic logic [3:0] cfg_default(input int idx);
    case (idx)
      0: cfg_default = `CGPIO_CFG_RST0;
      1: cfg_default = `CGPIO_CFG_RST1;
      2: cfg_default = `CGPIO_CFG_RST2;
      3: cfg_default = `CGPIO_CFG_RST3;
      default: cfg_default = `CGPIO_CFG_RST4;
    endcase
  endfunction : cfg_default

  // Pins come from outside the clock domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else if (ce_i) begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
    end
  end

  assign tick = (samp_cnt_r == 32'(SAMPLE_CYC - 1));
  assign wr = cyc_i && stb_i && we_i && !ack_o;
  assign rd = cyc_i && stb_i && !ack_o;
  // Command strobes watched by the checks
  assign cmd_go = wr && sel_i == 4'hF && adr_i == `CGPIO_OFF_CMD
                  && arg_r[7:0] < `CGPIO_NUM_PINS;
  assign poll0 = cmd_go && dat_i[7:0] == `CGPIO_CMD_READ && arg_r[2:0] == 3'h0;

  always_comb begin
    // RL2 free-running 32 Hz sampler
    samp_cnt_nxt = tick ? 32'h00000000 : samp_cnt_r + 32'h00000001;
    step_nxt = (step_cnt_r == 32'(PWM_STEP_CYC - 1));
    step_cnt_nxt = step_nxt ? 32'h00000000 : step_cnt_r + 32'h00000001;
    lvl_nxt = lvl_r;
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    arg_nxt = arg_r;
    resp_nxt = resp_r;
    rtype_nxt = rtype_r;
    for (int i = 0; i < 5; i++) begin
      val_nxt[i] = val_r[i];
      cfg_nxt[i] = cfg_r[i];
      boot_nxt[i] = boot_r[i];
    end
    // RL4 level and edges only from periodic samples
    // RL15 anything between two samples is lost
    if (tick) begin
      // RL14 report the real pin level
      lvl_nxt = sync2_r;
      // RL3 edges accumulate until polled
      rise_nxt = rise_r | (sync2_r & ~lvl_r);
      fall_nxt = fall_r | (~sync2_r & lvl_r);
    end
    if (wr && sel_i == 4'hF) begin
      unique case (adr_i)
        `CGPIO_OFF_ARG: arg_nxt = dat_i;
        `CGPIO_OFF_BOOT: begin
          // RL19 store configuration as boot state
          for (int i = 0; i < 5; i++) begin
            boot_nxt[i] = cfg_r[i];
          end
        end
        `CGPIO_OFF_CMD: begin
          // RL1 reserved indices select nothing
          if (arg_r[7:0] < `CGPIO_NUM_PINS) begin
            // RL5 set with two or three bytes
            if (dat_i[7:0] == `CGPIO_CMD_SET && arg_r[7:0] <= `CGPIO_VAL_HIGH + 8'h00
                && arg_r[15:8] <= `CGPIO_VAL_HIGH) begin
              val_nxt[arg_r[2:0]] = arg_r[15:8];
              if (dat_i[15:8] == 8'h03) begin
                cfg_nxt[arg_r[2:0]] = arg_r[19:16];
              end
              // RL11 acknowledge with no data
              rtype_nxt = `CGPIO_CMD_SET | `CGPIO_ACK_BIT;
              resp_nxt = 32'h00000000;
            end else if (dat_i[7:0] == `CGPIO_CMD_READ) begin
              // RL20 read answer type
              rtype_nxt = `CGPIO_CMD_READ | `CGPIO_ACK_BIT;
              // RL12 index then status byte
              // RL16 requested value
              // RL17 function and mode, upper bits zero
              resp_nxt = {4'h0, cfg_r[arg_r[2:0]], val_r[arg_r[2:0]],
                          5'h00, rise_nxt[arg_r[2:0]], fall_nxt[arg_r[2:0]],
                          lvl_nxt[arg_r[2:0]], arg_r[7:0]};
              // RL13 flags restart after report
              // A sample landing now is already in this report, so nothing is lost
              rise_nxt[arg_r[2:0]] = 1'b0;
              fall_nxt[arg_r[2:0]] = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
    dat_nxt = 32'h00000000;
    unique case (adr_i)
      `CGPIO_OFF_ARG: dat_nxt = arg_r;
      `CGPIO_OFF_RESP: dat_nxt = resp_r;
      `CGPIO_OFF_STAT: dat_nxt = {17'h00000, fall_r, rise_r, rtype_r[4:0]} ^
                                 {24'h000000, rtype_r & 8'hE0};
      `CGPIO_OFF_CMD: dat_nxt = {24'h000000, rtype_r};
      // Boot copy reads back so a store can be confirmed
      `CGPIO_OFF_BOOT: dat_nxt = {12'h000, boot_r[4], boot_r[3], boot_r[2], boot_r[1],
                                  boot_r[0]};
      default: dat_nxt = 32'h00000000;
    endcase
    ack_nxt = rd;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      samp_cnt_r <= 32'h00000000;
      step_cnt_r <= 32'h00000000;
      step_r <= 1'b0;
      lvl_r <= 5'h00;
      rise_r <= 5'h00;
      fall_r <= 5'h00;
      arg_r <= 32'h00000000;
      resp_r <= 32'h00000000;
      rtype_r <= 8'h00;
      dat_o <= 32'h00000000;
      ack_o <= 1'b0;
      for (int i = 0; i < 5; i++) begin
        val_r[i] <= 8'h00;
        // RL18 default functions at reset
        // RL19 boot state not restored; cfg_r and boot_r both take cfg_default
        // Boot copy is volatile, so reset reloads the defaults
        cfg_r[i] <= cfg_default(i);
        boot_r[i] <= cfg_default(i);
      end
    end else if (ce_i) begin
      samp_cnt_r <= samp_cnt_nxt;
      step_cnt_r <= step_cnt_nxt;
      step_r <= step_nxt;
      lvl_r <= lvl_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      arg_r <= arg_nxt;
      resp_r <= resp_nxt;
      rtype_r <= rtype_nxt;
      dat_o <= dat_nxt;
      ack_o <= ack_nxt;
      for (int i = 0; i < 5; i++) begin
        val_r[i] <= val_nxt[i];
        cfg_r[i] <= cfg_nxt[i];
        boot_r[i] <= boot_nxt[i];
      end
    end
  end

  for (genvar g = 0; g < 5; g++) begin : g_pin
    cgpio_pin_drv u_drv (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .step_i(step_r),
      .value_i(val_r[g]),
      .mode_i(cfg_r[g][2:0]),
      .user_i(cfg_r[g][`CGPIO_FUNC_BIT]),
      .dflt_o_i(dflt_o_i[g]),
      .dflt_oe_i(dflt_oe_i[g]),
      .pin_o(pin_o[g]),
      .pin_oe_o(pin_oe_o[g]),
      .pull_up_o(pull_up_o[g]),
      .pull_dn_o(pull_dn_o[g]),
      .slow_o(slow_o[g])
    );
  end

  // Sampling and edge flags
  a_level_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
    (ce_i && !tick) |=> $stable(lvl_r)) else $error("level moved off a sample");

  a_level_take: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
    (ce_i && tick) |=> (lvl_r == $past(sync2_r))) else $error("level is not the sampled pin");

  a_rise_sets: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
    (ce_i && tick && sync2_r[0] && !lvl_r[0] && !poll0) |=> rise_r[0])
    else $error("rising edge not latched");

  a_fall_sets: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
    (ce_i && tick && !sync2_r[0] && lvl_r[0] && !poll0) |=> fall_r[0])
    else $error("falling edge not latched");

  a_poll_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
    (ce_i && poll0) |=> (!rise_r[0] && !fall_r[0]))
    else $error("edge flags not restarted after a poll");

  a_sample_tick: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
    (ce_i && tick) |=> (samp_cnt_r == 32'h0)) else $error("sampler not periodic");

  // Command decoding
  a_rsvd_index: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
    (ce_i && wr && sel_i == 4'hF && adr_i == 8'h00 && arg_r[7:0] > 8'h04)
    |=> $stable(rtype_r)) else $error("reserved index answered");

  a_rsvd_value: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
    (ce_i && cmd_go && dat_i[7:0] == `CGPIO_CMD_SET && arg_r[2:0] == 3'h0
     && arg_r[15:8] > `CGPIO_VAL_HIGH) |=> ($stable(rtype_r) && $stable(val_r[0])))
    else $error("invalid value taken");

  a_value_only: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
    (ce_i && cmd_go && dat_i[15:0] == {8'h02, `CGPIO_CMD_SET} && arg_r[2:0] == 3'h0)
    |=> $stable(cfg_r[0])) else $error("two-byte set changed the configuration");

  a_cfg_set: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
    (ce_i && cmd_go && dat_i[15:0] == {8'h03, `CGPIO_CMD_SET} && arg_r[2:0] == 3'h0
     && arg_r[15:8] <= `CGPIO_VAL_HIGH) |=> (cfg_r[0] == $past(arg_r[19:16])))
    else $error("three-byte set did not configure");

  a_set_ack: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
    (ce_i && wr && sel_i == 4'hF && adr_i == 8'h00 && dat_i[7:0] == 8'h22
     && arg_r[7:0] < 8'h05 && arg_r[15:8] <= 8'h64)
    |=> (rtype_r == 8'h62 && resp_r == 32'h0)) else $error("set ack wrong");

  a_read_type: assert property (@(posedge clk_i) disable iff (rst_i) // RL20
    (ce_i && wr && sel_i == 4'hF && adr_i == 8'h00 && dat_i[7:0] == 8'h23
     && arg_r[7:0] < 8'h05) |=> (rtype_r == 8'h63 && resp_r[31:28] == 4'h0))
    else $error("read answer wrong");

  a_read_value: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
    (ce_i && poll0) |=> (resp_r[23:16] == $past(val_r[0])))
    else $error("read did not return the requested value");

  // Bus and boot copy
  a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i) // RL20
    (ce_i && cyc_i && stb_i && !ack_o) |=> ack_o) else $error("no ack");

  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // RL20
    (ce_i && ack_o) |=> !ack_o) else $error("ack held past one cycle");

  a_boot_store: assert property (@(posedge clk_i) disable iff (rst_i) // RL19
    (ce_i && wr && sel_i == 4'hF && adr_i == `CGPIO_OFF_BOOT)
    |=> (boot_r[0] == $past(cfg_r[0]))) else $error("configuration not stored");
endmodule : cgpio_port
`default_nettype wire

/* sim/cgpio_pin_load.sv */
// Pad load model: resolves each pad from port drive, external source and pulls
`timescale 1ns/100ps
`default_nettype none
module cgpio_pin_load (
  // Clock
  input wire logic clk_i,
  // Port drive
  input wire logic [4:0] pin_o,
  input wire logic [4:0] pin_oe_o,
  input wire logic [4:0] pull_up_o,
  input wire logic [4:0] pull_dn_o,
  // External source
  input wire logic [4:0] ext_lvl_i,
  input wire logic [4:0] ext_en_i,
  // Pad level
  output logic [4:0] pad_o
);
  logic [4:0] float_r = 5'h00;
  // Undriven pads wander so a stale level never passes
  always_ff @(posedge clk_i) begin
    float_r <= float_r + 5'h01;
  end
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pin_oe_o[i]) pad_o[i] = pin_o[i];
      else if (ext_en_i[i]) pad_o[i] = ext_lvl_i[i];
      else if (pull_up_o[i] || i == 4) pad_o[i] = 1'b1;
      else if (pull_dn_o[i]) pad_o[i] = 1'b0;
      else pad_o[i] = float_r[i];
    end
  end
endmodule : cgpio_pin_load
`default_nettype wire

/* sim/tb_top.sv */
// Testbench of the command driven pin port
`timescale 1ns/100ps
`default_nettype none
`include "cgpio_regs.svh"
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o, q;
  logic ack_o;
  logic [4:0] pad, pin_o, pin_oe_o, pull_up_o, pull_dn_o, slow_o;
  logic [4:0] ext_lvl = 5'h00;
  logic [4:0] ext_en = 5'h02;
  logic [4:0] dflt_o = 5'h00;
  logic [4:0] dflt_oe = 5'h00;
  // Per drive mode, bit m: oe/pull-up/slow at level 1, oe/pull-down/slow at level 0
  logic [7:0] oe_hi = 8'h33, pu_hi = 8'h08, sl_hi = 8'h30;
  logic [7:0] oe_lo = 8'hAA, pd_lo = 8'h01, sl_lo = 8'hA0;
  int fails = 0;
  int total_checks = 0;
  int hi;
  always #2.5 clk_i = ~clk_i;
  cgpio_port #(.SAMPLE_CYC(50), .PWM_STEP_CYC(2)) cgpio_port_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pin_i(pad),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o), .pull_dn_o(pull_dn_o),
    .slow_o(slow_o), .dflt_o_i(dflt_o), .dflt_oe_i(dflt_oe));
  cgpio_pin_load cgpio_pin_load_inst (
    .clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o),
    .pull_dn_o(pull_dn_o), .ext_lvl_i(ext_lvl), .ext_en_i(ext_en), .pad_o(pad));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    if (ack_o !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: no bus answer", $time);
      end_sim();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  // Argument word, command word, then answer type into q
  task automatic cmd(input logic [7:0] ty, len, idx, val, input logic [3:0] cfg);
    wb(1'b1, `CGPIO_OFF_ARG, {12'h000, cfg, val, idx});
    wb(1'b1, `CGPIO_OFF_CMD, {16'h0000, len, ty});
    wb(1'b0, `CGPIO_OFF_CMD, 32'h00000000);
  endtask : cmd
  task automatic rd(input logic [7:0] idx);
    cmd(`CGPIO_CMD_READ, 8'h01, idx, 8'h00, 4'h0);
    check(q[7:0], `CGPIO_CMD_READ | `CGPIO_ACK_BIT, "read type");
    wb(1'b0, `CGPIO_OFF_RESP, 32'h00000000);
  endtask : rd
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(i[7:0]);
      check({q[27:16], q[7:0]},
            {(i == 1 || i == 4) ? 4'h3 : 4'h2, 8'h00, i[7:0]}, "boot cfg");
      check({q[31:28], q[15:11]}, 0, "reserved");
    end
    $display("test reset config done");
    cmd(`CGPIO_CMD_SET, 8'h03, 8'h00, 8'h64, 4'h9);
    check(q[7:0], `CGPIO_CMD_SET | `CGPIO_ACK_BIT, "set type");
    wb(1'b0, `CGPIO_OFF_RESP, 32'h00000000);
    check(q, 0, "set data");
    repeat (120) @(posedge clk_i);
    check({pin_oe_o[0], pin_o[0]}, 2'b11, "high out");
    rd(8'h00);
    check({q[27:16], q[8]}, {4'h9, 8'h64, 1'b1}, "pin0 read");
    cmd(`CGPIO_CMD_SET, 8'h02, 8'h00, 8'h00, 4'h0);
    repeat (3) @(posedge clk_i);
    check({pin_oe_o[0], pin_o[0]}, 2'b10, "low out");
    rd(8'h00);
    check(q[27:16], {4'h9, 8'h00}, "value only");
    cmd(`CGPIO_CMD_SET, 8'h03, 8'h05, 8'h32, 4'h9);
    check(q[7:0], 8'h63, "bad index");
    cmd(`CGPIO_CMD_SET, 8'h02, 8'h00, 8'h65, 4'h0);
    check(q[7:0], 8'h63, "bad value");
    cmd(`CGPIO_CMD_SET, 8'h02, 8'h00, 8'h32, 4'h0);
    hi = 0;
    repeat (400) begin
      @(posedge clk_i);
      hi += int'(pin_o[0]);
    end
    check(hi >= 196 && hi <= 204, 1, "pwm duty");
    $display("test set and pwm done");
    for (int m = 0; m < 8; m++) begin
      if (m == 6) continue;
      for (int v = 0; v < 2; v++) begin
        cmd(`CGPIO_CMD_SET, 8'h03, 8'h03, v ? 8'h64 : 8'h00, {1'b1, m[2:0]});
        repeat (3) @(posedge clk_i);
        check({pin_oe_o[3], pin_o[3] & pin_oe_o[3], pull_up_o[3] & ~pin_oe_o[3],
               pull_dn_o[3] & ~pin_oe_o[3], slow_o[3] & pin_oe_o[3]},
              v ? {oe_hi[m], oe_hi[m], pu_hi[m], 1'b0, sl_hi[m]}
                : {oe_lo[m], 1'b0, 1'b0, pd_lo[m], sl_lo[m]}, "drive");
      end
      rd(8'h03);
      check(q[27:24], {1'b1, m[2:0]}, "mode read");
    end
    $display("test drive modes done");
    dflt_oe <= 5'h04;
    dflt_o <= 5'h04;
    repeat (3) @(posedge clk_i);
    check({pin_oe_o[2], pin_o[2]}, 2'b11, "default fn");
    cmd(`CGPIO_CMD_SET, 8'h03, 8'h02, 8'h64, 4'hA);
    repeat (3) @(posedge clk_i);
    check(pin_oe_o[2], 0, "user fn");
    ext_lvl <= 5'h02;
    repeat (150) @(posedge clk_i);
    rd(8'h01);
    check(q[10:8], 3'b101, "rise seen");
    rd(8'h01);
    check(q[10:8], 3'b001, "flags cleared");
    ext_lvl <= 5'h00;
    repeat (150) @(posedge clk_i);
    rd(8'h01);
    check(q[10:8], 3'b010, "fall seen");
    wb(1'b1, `CGPIO_OFF_BOOT, 32'h00000000);
    wb(1'b0, `CGPIO_OFF_BOOT, 32'h00000000);
    check(q, 32'h0003FA39, "boot copy");
    $display("test function and edges done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
